/* File: shared/mbs_pkg.sv */
package mbs_pkg;
   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int MS_NS = 1_000_000;
   localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
   localparam int TMO_UNIT_MS = 100;
   localparam int IDLE_HALF_CHARS = 7;
   localparam int CHAR_BITS_1STOP = 10;
   localparam int CHAR_BITS_2STOP = 11;
   // ------------------------------------------------------------
   // Setting indices, reset values and limits
   // ------------------------------------------------------------
   localparam logic [3:0] IDX_RATE = 4'h0;
   localparam logic [3:0] IDX_FMT = 4'h1;
   localparam logic [3:0] IDX_ADDR = 4'h2;
   localparam logic [3:0] IDX_DLY = 4'h3;
   localparam logic [3:0] IDX_TMO = 4'h4;
   localparam logic [3:0] IDX_VAR = 4'h5;
   localparam logic [3:0] IDX_SCALE = 4'h6;
   localparam logic [3:0] IDX_FAULT = 4'hf;
   localparam logic [3:0] RATE_RST = 4'h5;
   localparam logic [3:0] RATE_MAX = 4'h8;
   localparam logic [1:0] FMT_RST = 2'h0;
   localparam logic [1:0] FMT_8N2 = 2'h0;
   localparam logic [1:0] FMT_8E1 = 2'h1;
   localparam logic [1:0] FMT_8O1 = 2'h2;
   localparam logic [1:0] FMT_8N1 = 2'h3;
   localparam logic [7:0] ADDR_RST = 8'h01;
   localparam logic [7:0] ADDR_MAX = 8'hf7;
   localparam logic [7:0] ADDR_BCAST = 8'h00;
   localparam logic [4:0] DLY_RST = 5'h02;
   localparam logic [4:0] DLY_MAX = 5'h14;
   localparam logic [9:0] TMO_RST = 10'h000;
   localparam logic [9:0] TMO_MAX = 10'h258;
   localparam logic VAR_RST = 1'b0;
   localparam logic SCALE_RST = 1'b0;
   // ------------------------------------------------------------
   // Frame constants and fault codes
   // ------------------------------------------------------------
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam logic [7:0] FC_READ = 8'h03;
   localparam logic [7:0] PAD_BYTE = 8'h00;
   localparam logic [7:0] MIN_FRAME = 8'h04;
   localparam logic [15:0] FAULT_NONE = 16'h0000;
   localparam logic [15:0] FAULT_COMM = 16'h0010;
   // ------------------------------------------------------------
   // Reply sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MBS_IDLE = 3'b000,
      MBS_WAIT = 3'b001,
      MBS_DATA = 3'b011,
      MBS_PAD = 3'b010,
      MBS_CRCL = 3'b110,
      MBS_CRCH = 3'b111
   } mbs_state_e;
   // Clock cycles per bit for a rate code; unknown codes give the top rate.
   function automatic logic [16:0] mbs_div(input logic [3:0] code);
      int rate;
      case (code)
         4'h0: rate = 300;
         4'h1: rate = 600;
         4'h2: rate = 1200;
         4'h3: rate = 2400;
         4'h4: rate = 4800;
         4'h5: rate = 9600;
         4'h6: rate = 19200;
         4'h7: rate = 38400;
         default: rate = 57600;
      endcase
      return 17'(CLK_HZ / rate);
   endfunction
endpackage

/* File: rtl/mbs_crc16.sv */
`timescale 1ns/1ps
module mbs_crc16
   import mbs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Byte stream
   input wire logic clr,
   input wire logic en,
   input wire logic [7:0] data,
   output logic [15:0] crc
);
   logic [15:0] crc_reg;
   logic [15:0] crc_next;

   always_comb begin
      crc_next = crc_reg ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         crc_next = crc_next[0] ? ((crc_next >> 1) ^ CRC_POLY) : (crc_next >> 1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst || clr) begin
         crc_reg <= CRC_INIT;
      end else if (en) begin
         crc_reg <= crc_next;
      end
   end

   assign crc = crc_reg;
endmodule

/* File: rtl/mbs_uart_rx.sv */
`timescale 1ns/1ps
module mbs_uart_rx
   import mbs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Line and settings
   input wire logic rxd,
   input wire logic [16:0] div,
   input wire logic [1:0] fmt,
   // Received byte
   output logic [7:0] data,
   output logic valid,
   output logic err
);
   logic busy_reg;
   logic [16:0] cnt_reg;
   logic [3:0] bitn_reg;
   logic [7:0] sh_reg;
   logic valid_reg;
   logic err_reg;
   logic has_par;
   logic par_exp;

   assign has_par = (fmt == FMT_8E1) || (fmt == FMT_8O1);
   assign par_exp = (^sh_reg) ^ (fmt == FMT_8O1);

   always_ff @(posedge clk) begin
      valid_reg <= 1'b0;
      if (rst) begin
         busy_reg <= 1'b0;
         cnt_reg <= 17'h00000;
         bitn_reg <= 4'h0;
         sh_reg <= 8'h00;
         err_reg <= 1'b0;
      end else if (!busy_reg) begin
         if (!rxd) begin
            busy_reg <= 1'b1;
            cnt_reg <= div >> 1;
            bitn_reg <= 4'h0;
            err_reg <= 1'b0;
         end
      end else if (cnt_reg != 17'h00000) begin
         cnt_reg <= cnt_reg - 17'h00001;
      end else begin
         cnt_reg <= div - 17'h00001;
         bitn_reg <= bitn_reg + 4'h1;
         if (bitn_reg == 4'h0) begin
            // A start bit that is high again was a glitch.
            busy_reg <= !rxd;
         end else if (bitn_reg <= 4'h8) begin
            sh_reg <= {rxd, sh_reg[7:1]};
         end else if (bitn_reg == 4'h9 && has_par) begin
            err_reg <= (rxd != par_exp);
         end else begin
            // Only the first stop bit is checked, so 8N2 resyncs early.
            busy_reg <= 1'b0;
            valid_reg <= 1'b1;
            err_reg <= err_reg | !rxd;
         end
      end
   end

   assign data = sh_reg;
   assign valid = valid_reg;
   assign err = err_reg;
endmodule

/* File: rtl/mbs_link.sv */
`timescale 1ns/1ps
// Function
// - Bit rate from four-bit selection code
// - Character format from two-bit code
// - Station address 1 to 247, 0 broadcast
// - Accept only own-address or broadcast frames
// - Address 0: execute broadcasts, never reply
// - Turnaround delay 0 to 20 ms
// - Reply at later of processing or delay
// - Timeout fault after configured silent time
// - Zero timeout disables loss detection
// - Standard reply framing when variant is 1
// - Variant 0 adds one byte to reads
// - Current read scale 0.01 A or 0.1 A
// - Sixteen-bit fault code word readable
// - Fault kinds carry distinct codes
// - Check value: all ones, shift, xor constant
// - Check value sent low byte first
module mbs_link
   import mbs_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYC
)
(
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // Serial line
   input wire logic RXD,
   output logic TXD,
   output logic TX_EN,
   // Parameter store access
   input wire logic PARAM_WE,
   input wire logic [3:0] PARAM_IDX,
   input wire logic [15:0] PARAM_WDATA,
   output logic [15:0] PARAM_RDATA,
   // Received frame stream
   output logic [7:0] FRM_DATA,
   output logic FRM_VALID,
   output logic FRM_GOOD,
   output logic FRM_BAD,
   output logic FRM_BCAST,
   // Reply stream from processing
   input wire logic [7:0] RPL_DATA,
   input wire logic RPL_VALID,
   input wire logic RPL_LAST,
   output logic RPL_READY,
   // Drive status
   input wire logic [15:0] DRIVE_FAULT,
   input wire logic FAULT_CLR,
   output logic LINK_TIMEOUT_FAULT,
   output logic CUR_SCALE_SEL
);
   // ------------------------------------------------------------
   // Settings
   // ------------------------------------------------------------
   logic [3:0] rate_reg;
   logic [1:0] fmt_reg;
   logic [7:0] addr_reg;
   logic [4:0] dly_reg;
   logic [9:0] tmo_reg;
   logic var_reg;
   logic scale_reg;
   logic [15:0] rdata_reg;
   logic [15:0] fault_word;
   logic link_fault_reg;

   // Out-of-range writes are dropped so the setting never leaves its range.
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         rate_reg <= RATE_RST;
         fmt_reg <= FMT_RST;
         addr_reg <= ADDR_RST;
         dly_reg <= DLY_RST;
         tmo_reg <= TMO_RST;
         var_reg <= VAR_RST;
         scale_reg <= SCALE_RST;
      end else if (PARAM_WE) begin
         case (PARAM_IDX)
            IDX_RATE: if (PARAM_WDATA <= 16'(RATE_MAX)) rate_reg <= PARAM_WDATA[3:0];
            IDX_FMT: if (PARAM_WDATA <= 16'(FMT_8N1)) fmt_reg <= PARAM_WDATA[1:0];
            IDX_ADDR: if (PARAM_WDATA <= 16'(ADDR_MAX)) addr_reg <= PARAM_WDATA[7:0];
            IDX_DLY: if (PARAM_WDATA <= 16'(DLY_MAX)) dly_reg <= PARAM_WDATA[4:0];
            IDX_TMO: if (PARAM_WDATA <= 16'(TMO_MAX)) tmo_reg <= PARAM_WDATA[9:0];
            IDX_VAR: if (PARAM_WDATA <= 16'h0001) var_reg <= PARAM_WDATA[0];
            IDX_SCALE: if (PARAM_WDATA <= 16'h0001) scale_reg <= PARAM_WDATA[0];
            default: ;
         endcase
      end
   end

   // A pending drive fault outranks the link fault in the code word.
   assign fault_word = (DRIVE_FAULT != FAULT_NONE) ? DRIVE_FAULT :
                       (link_fault_reg ? FAULT_COMM : FAULT_NONE);

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         rdata_reg <= 16'h0000;
      end else begin
         case (PARAM_IDX)
            IDX_RATE: rdata_reg <= 16'(rate_reg);
            IDX_FMT: rdata_reg <= 16'(fmt_reg);
            IDX_ADDR: rdata_reg <= 16'(addr_reg);
            IDX_DLY: rdata_reg <= 16'(dly_reg);
            IDX_TMO: rdata_reg <= 16'(tmo_reg);
            IDX_VAR: rdata_reg <= 16'(var_reg);
            IDX_SCALE: rdata_reg <= 16'(scale_reg);
            IDX_FAULT: rdata_reg <= fault_word;
            default: rdata_reg <= 16'h0000;
         endcase
      end
   end

   assign PARAM_RDATA = rdata_reg;
   assign CUR_SCALE_SEL = scale_reg;
   assign LINK_TIMEOUT_FAULT = link_fault_reg;

   // ------------------------------------------------------------
   // Bit and millisecond timing
   // ------------------------------------------------------------
   logic [16:0] div;
   logic [16:0] bt_cnt_reg;
   logic bit_tick;
   logic [3:0] char_bits;
   logic [5:0] idle_lim;
   logic [15:0] ms_cnt_reg;
   logic ms_tick;
   logic tx_load;

   assign div = mbs_div(rate_reg);
   assign bit_tick = (bt_cnt_reg == 17'h00000);
   assign char_bits = (fmt_reg == FMT_8N1) ? 4'(CHAR_BITS_1STOP) : 4'(CHAR_BITS_2STOP);
   assign idle_lim = 6'((IDLE_HALF_CHARS * int'(char_bits) + 1) / 2);
   assign ms_tick = (ms_cnt_reg == 16'h0000);

   // Restarting on a load keeps every transmitted bit a full period long.
   always_ff @(posedge CLK_SYS) begin
      if (RST || tx_load || bit_tick) begin
         bt_cnt_reg <= div - 17'h00001;
      end else begin
         bt_cnt_reg <= bt_cnt_reg - 17'h00001;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST || ms_tick) begin
         ms_cnt_reg <= 16'(MS_CYCLES - 1);
      end else begin
         ms_cnt_reg <= ms_cnt_reg - 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // Receive framing
   // ------------------------------------------------------------
   logic [7:0] rx_data;
   logic rx_valid;
   logic rx_err;
   logic [15:0] rx_crc;
   logic in_frame_reg;
   logic [5:0] idle_cnt_reg;
   logic [7:0] nbytes_reg;
   logic bad_reg;
   logic addr_ok_reg;
   logic bcast_reg;
   logic frame_end;
   logic frame_good;
   logic frm_valid_reg;
   logic [7:0] frm_data_reg;
   logic frm_good_reg;
   logic frm_bad_reg;

   mbs_uart_rx u_rx (
      .clk(CLK_SYS),
      .rst(RST),
      .rxd(RXD),
      .div(div),
      .fmt(fmt_reg),
      .data(rx_data),
      .valid(rx_valid),
      .err(rx_err)
   );

   mbs_crc16 u_rx_crc (
      .clk(CLK_SYS),
      .rst(RST),
      .clr(frame_end),
      .en(rx_valid),
      .data(rx_data),
      .crc(rx_crc)
   );

   assign frame_end = in_frame_reg && (idle_cnt_reg == idle_lim);
   // A frame that carries its own check leaves a zero residue.
   assign frame_good = frame_end && !bad_reg && (rx_crc == 16'h0000) &&
                       (nbytes_reg >= MIN_FRAME) && (addr_ok_reg || bcast_reg);

   always_ff @(posedge CLK_SYS) begin
      if (RST || !RXD || rx_valid) begin
         idle_cnt_reg <= 6'h00;
      end else if (in_frame_reg && bit_tick && idle_cnt_reg != idle_lim) begin
         idle_cnt_reg <= idle_cnt_reg + 6'h01;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      frm_valid_reg <= 1'b0;
      if (RST || frame_end) begin
         in_frame_reg <= 1'b0;
         nbytes_reg <= 8'h00;
         bad_reg <= 1'b0;
         addr_ok_reg <= 1'b0;
         bcast_reg <= 1'b0;
      end else if (rx_valid) begin
         in_frame_reg <= 1'b1;
         frm_valid_reg <= 1'b1;
         if (nbytes_reg != 8'hff) begin
            nbytes_reg <= nbytes_reg + 8'h01;
         end
         if (nbytes_reg == 8'h00) begin
            addr_ok_reg <= (rx_data == addr_reg) && (addr_reg != ADDR_BCAST);
            bcast_reg <= (rx_data == ADDR_BCAST);
         end
         bad_reg <= bad_reg | rx_err;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         frm_data_reg <= 8'h00;
         frm_good_reg <= 1'b0;
         frm_bad_reg <= 1'b0;
      end else begin
         if (rx_valid) begin
            frm_data_reg <= rx_data;
         end
         frm_good_reg <= frame_good;
         frm_bad_reg <= frame_end && !frame_good;
      end
   end

   assign FRM_DATA = frm_data_reg;
   assign FRM_VALID = frm_valid_reg;
   assign FRM_GOOD = frm_good_reg;
   assign FRM_BAD = frm_bad_reg;
   assign FRM_BCAST = bcast_reg;

   // ------------------------------------------------------------
   // Communication-loss supervision
   // ------------------------------------------------------------
   logic [15:0] tmo_cnt_reg;
   logic [15:0] tmo_lim;
   logic tmo_set;

   assign tmo_lim = 16'(int'(tmo_reg) * TMO_UNIT_MS);
   assign tmo_set = (tmo_reg != TMO_RST) && ms_tick &&
                    (tmo_cnt_reg == tmo_lim - 16'h0001);

   always_ff @(posedge CLK_SYS) begin
      if (RST || frame_good) begin
         tmo_cnt_reg <= 16'h0000;
      end else if (ms_tick && tmo_cnt_reg < tmo_lim) begin
         tmo_cnt_reg <= tmo_cnt_reg + 16'h0001;
      end
   end

   // A new timeout in the clearing cycle keeps the fault set.
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         link_fault_reg <= 1'b0;
      end else begin
         link_fault_reg <= tmo_set || (link_fault_reg && !FAULT_CLR);
      end
   end

   // ------------------------------------------------------------
   // Reply sequencing and transmit
   // ------------------------------------------------------------
   mbs_state_e st_reg;
   logic [4:0] dly_cnt_reg;
   logic dly_done;
   logic [1:0] rpl_idx_reg;
   logic rd_reg;
   logic rd_now;
   logic accept;
   logic [15:0] tx_crc;
   logic [7:0] tx_byte;
   logic tx_busy_reg;
   logic [10:0] tx_sh_reg;
   logic [3:0] tx_n_reg;
   logic tx_en_reg;
   logic par_bit;

   // The millisecond prescaler runs free, so one extra tick is waited to never cut the delay short.
   assign dly_done = (dly_reg == 5'h00) || (dly_cnt_reg > dly_reg);
   // Outside a reply, stray bytes are drained so nothing is ever sent.
   assign RPL_READY = (st_reg == MBS_IDLE) || ((st_reg == MBS_DATA) && !tx_busy_reg);
   assign accept = (st_reg == MBS_DATA) && !tx_busy_reg && RPL_VALID;
   assign rd_now = rd_reg || ((rpl_idx_reg == 2'h1) && (RPL_DATA == FC_READ));
   assign tx_load = accept || (!tx_busy_reg &&
                    (st_reg == MBS_PAD || st_reg == MBS_CRCL || st_reg == MBS_CRCH));

   always_comb begin
      case (st_reg)
         MBS_PAD: tx_byte = PAD_BYTE;
         MBS_CRCL: tx_byte = tx_crc[7:0];
         MBS_CRCH: tx_byte = tx_crc[15:8];
         default: tx_byte = RPL_DATA;
      endcase
   end

   mbs_crc16 u_tx_crc (
      .clk(CLK_SYS),
      .rst(RST),
      .clr(st_reg == MBS_WAIT),
      .en(tx_load && (st_reg == MBS_DATA || st_reg == MBS_PAD)),
      .data(tx_byte),
      .crc(tx_crc)
   );

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         st_reg <= MBS_IDLE;
         dly_cnt_reg <= 5'h00;
         rpl_idx_reg <= 2'h0;
         rd_reg <= 1'b0;
      end else begin
         case (st_reg)
            MBS_IDLE: begin
               dly_cnt_reg <= 5'h00;
               rpl_idx_reg <= 2'h0;
               rd_reg <= 1'b0;
               if (frame_good && addr_ok_reg) begin
                  st_reg <= MBS_WAIT;
               end
            end
            MBS_WAIT: begin
               if (ms_tick && !dly_done) begin
                  dly_cnt_reg <= dly_cnt_reg + 5'h01;
               end
               if (dly_done && RPL_VALID) begin
                  st_reg <= MBS_DATA;
               end
            end
            MBS_DATA: begin
               if (accept) begin
                  if (rpl_idx_reg != 2'h3) begin
                     rpl_idx_reg <= rpl_idx_reg + 2'h1;
                  end
                  rd_reg <= rd_now;
                  if (RPL_LAST) begin
                     st_reg <= (!var_reg && rd_now) ? MBS_PAD : MBS_CRCL;
                  end
               end
            end
            MBS_PAD: if (tx_load) st_reg <= MBS_CRCL;
            MBS_CRCL: if (tx_load) st_reg <= MBS_CRCH;
            MBS_CRCH: if (tx_load) st_reg <= MBS_IDLE;
            default: st_reg <= MBS_IDLE;
         endcase
      end
   end

   assign par_bit = (fmt_reg == FMT_8E1) ? ^tx_byte : ((fmt_reg == FMT_8O1) ? ~^tx_byte : 1'b1);

   // Shift register idles at all ones, so the line rests at the stop level.
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         tx_sh_reg <= 11'h7ff;
         tx_n_reg <= 4'h0;
         tx_busy_reg <= 1'b0;
      end else if (tx_load) begin
         tx_sh_reg <= {1'b1, par_bit, tx_byte, 1'b0};
         tx_n_reg <= char_bits;
         tx_busy_reg <= 1'b1;
      end else if (tx_busy_reg && bit_tick) begin
         tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
         tx_n_reg <= tx_n_reg - 4'h1;
         tx_busy_reg <= (tx_n_reg != 4'h1);
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         tx_en_reg <= 1'b0;
      end else begin
         tx_en_reg <= tx_busy_reg || tx_load ||
                      (st_reg != MBS_IDLE && st_reg != MBS_WAIT);
      end
   end

   assign TXD = tx_sh_reg[0];
   assign TX_EN = tx_en_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_RATE_9600: assert property (@(posedge CLK_SYS) disable iff (RST)
      rate_reg == 4'h5 |-> div == 17'd2604)
      else $error("rate code 5 does not give 9600 bit/s divisor");
   AST_CHAR_LEN: assert property (@(posedge CLK_SYS) disable iff (RST)
      tx_load |=> tx_n_reg == ((fmt_reg == 2'h3) ? 4'd10 : 4'd11) && tx_sh_reg[0] == 1'b0)
      else $error("character length or start bit wrong");
   AST_ADDR_RANGE: assert property (@(posedge CLK_SYS) disable iff (RST)
      addr_reg <= 8'd247)
      else $error("station address out of range");
   AST_NO_BCAST_REPLY: assert property (@(posedge CLK_SYS) disable iff (RST)
      (st_reg == MBS_IDLE && frame_end && addr_reg == 8'h00) |=> st_reg == MBS_IDLE)
      else $error("reply started with broadcast-only address");
   AST_WAIT_DELAY: assert property (@(posedge CLK_SYS) disable iff (RST)
      (st_reg == MBS_WAIT && dly_reg != 5'h00 && dly_cnt_reg <= dly_reg) |=> st_reg != MBS_DATA)
      else $error("reply began before turnaround expired");
   AST_TMO_OFF: assert property (@(posedge CLK_SYS) disable iff (RST)
      (tmo_reg == 10'h000 && !link_fault_reg) |=> !link_fault_reg)
      else $error("timeout fault with detection disabled");
   AST_TMO_FIRE: assert property (@(posedge CLK_SYS) disable iff (RST)
      (tmo_reg != 10'h000 && ms_tick && tmo_cnt_reg == tmo_lim - 16'h0001 && !frame_good)
      |=> link_fault_reg && tmo_cnt_reg == tmo_lim)
      else $error("timeout fault not raised at limit");
   AST_CRC_LOW_FIRST: assert property (@(posedge CLK_SYS) disable iff (RST)
      (st_reg == MBS_CRCL && tx_load) |=> tx_sh_reg[8:1] == $past(tx_crc[7:0])
      && st_reg == MBS_CRCH)
      else $error("check value low byte not sent first");
   AST_READ_PAD: assert property (@(posedge CLK_SYS) disable iff (RST)
      (accept && RPL_LAST && rd_now && !var_reg) |=> st_reg == MBS_PAD)
      else $error("extended read reply missing its extra byte");
   AST_DISCARD: assert property (@(posedge CLK_SYS) disable iff (RST)
      (frame_end && bad_reg) |=> !frm_good_reg && frm_bad_reg)
      else $error("bad frame not discarded");
   AST_FAULT_WORD: assert property (@(posedge CLK_SYS) disable iff (RST)
      (link_fault_reg && DRIVE_FAULT == 16'h0000 && PARAM_IDX == 4'hf)
      |=> PARAM_RDATA == 16'h0010)
      else $error("fault word does not show communication fault");
endmodule

/* File: dv/mbs_host_model.sv */
`timescale 1ns/1ps
module mbs_host_model
   import mbs_pkg::*;
(
   // Line to the device
   input wire logic CLK_SYS,
   input wire logic TXD,
   output logic RXD
);
   // Only 8N1 at the top rate is spoken, so the device must be set the same way first.
   localparam int BIT_CYC = 434;
   initial RXD = 1'b1;
   logic [7:0] got [8];
   int ngot = 0;
   // Replies are caught at mid-bit; the ninth pass waits to mid stop bit without sampling it before rearming.
   always begin
      @(negedge TXD);
      repeat (BIT_CYC / 2) @(posedge CLK_SYS);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT_CYC) @(posedge CLK_SYS);
         if (i < 8 && ngot < 8) got[ngot][i] = TXD;
      end
      ngot++;
   end
   function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] b);
      c = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction
   task automatic put(input logic [7:0] b);
      logic [9:0] sh;
      sh = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         RXD <= sh[i];
         repeat (BIT_CYC) @(posedge CLK_SYS);
      end
   endtask
   task automatic send(input logic [7:0] a, input logic [7:0] f);
      logic [15:0] c;
      c = crc_add(crc_add(CRC_INIT, a), f);
      put(a);
      put(f);
      put(c[7:0]);
      put(c[15:8]);
   endtask
endmodule

/* File: dv/mbs_link_bench.sv */
`timescale 1ns/1ps
module mbs_link_bench
   import mbs_pkg::*;
;
   logic CLK_SYS = 1'b0, RST = 1'b1, PARAM_WE = 1'b0, RPL_VALID = 1'b0, RPL_LAST = 1'b0;
   logic FAULT_CLR = 1'b0, RXD, TX_EN, FRM_GOOD, FRM_BAD, RPL_READY, LINK_TIMEOUT_FAULT;
   logic CUR_SCALE_SEL, g, b, TXD, FRM_VALID, FRM_BCAST;
   logic [3:0] PARAM_IDX = 4'h0;
   logic [7:0] RPL_DATA = 8'h00, FRM_DATA;
   logic [15:0] PARAM_WDATA = 16'h0000, PARAM_RDATA, DRIVE_FAULT = 16'h0000;
   logic [15:0] rst_tbl [7] = '{16'h5, 16'h0, 16'h1, 16'h2, 16'h0, 16'h0, 16'h0};
   int failures = 0, check_count = 0, cyc = 0, tx_hi = 0, tx_rise = 0, t_good, dly, n;
   int nval = 0, bc_seen = 0;
   always #20 CLK_SYS = ~CLK_SYS;
   // A 1 ms tick of 50 cycles keeps delays and the loss timer short.
   mbs_link #(.MS_CYCLES(50)) i_dut (.CLK_SYS(CLK_SYS), .RST(RST), .RXD(RXD), .TXD(TXD),
      .TX_EN(TX_EN), .PARAM_WE(PARAM_WE), .PARAM_IDX(PARAM_IDX), .PARAM_WDATA(PARAM_WDATA),
      .PARAM_RDATA(PARAM_RDATA), .FRM_DATA(FRM_DATA), .FRM_VALID(FRM_VALID),
      .FRM_GOOD(FRM_GOOD), .FRM_BAD(FRM_BAD), .FRM_BCAST(FRM_BCAST), .RPL_DATA(RPL_DATA),
      .RPL_VALID(RPL_VALID),
      .RPL_LAST(RPL_LAST), .RPL_READY(RPL_READY), .DRIVE_FAULT(DRIVE_FAULT),
      .FAULT_CLR(FAULT_CLR), .LINK_TIMEOUT_FAULT(LINK_TIMEOUT_FAULT),
      .CUR_SCALE_SEL(CUR_SCALE_SEL));
   mbs_host_model i_host (.CLK_SYS(CLK_SYS), .TXD(TXD), .RXD(RXD));
   always @(posedge CLK_SYS) begin
      cyc <= cyc + 1;
      if (FRM_VALID === 1'b1) nval <= nval + 1;
      if (FRM_BCAST === 1'b1) bc_seen <= 1;
      if (TX_EN === 1'b1) begin
         tx_hi <= tx_hi + 1;
         if (tx_rise == 0) tx_rise <= cyc;
      end
   end
   task automatic conclude();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic hang();
      failures++;
      conclude();
   endtask
   task automatic wr(input logic [3:0] i, input logic [15:0] d);
      PARAM_WE <= 1'b1;
      PARAM_IDX <= i;
      PARAM_WDATA <= d;
      @(posedge CLK_SYS);
      PARAM_WE <= 1'b0;
      @(posedge CLK_SYS);
   endtask
   task automatic rd(input logic [3:0] i, input logic [15:0] e);
      PARAM_IDX <= i;
      repeat (2) @(posedge CLK_SYS);
      chk("setting", PARAM_RDATA, e);
   endtask
   task automatic offer(input logic [7:0] d, input logic l);
      RPL_DATA <= d;
      RPL_LAST <= l;
      RPL_VALID <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK_SYS);
         n++;
      end while (RPL_READY !== 1'b1 && n < 20000);
      if (n >= 20000) hang();
   endtask
   task automatic frame(input logic [7:0] a);
      g = 1'b0;
      b = 1'b0;
      n = 0;
      i_host.send(a, FC_READ);
      while (g !== 1'b1 && b !== 1'b1 && n < 40000) begin
         @(posedge CLK_SYS);
         n++;
         g = FRM_GOOD;
         b = FRM_BAD;
      end
      if (n >= 40000) hang();
      t_good = cyc;
   endtask
   initial begin
      void'($urandom(32'h0a7a));
      repeat (10) @(posedge CLK_SYS);
      RST <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         rd(4'(i), rst_tbl[i]);
      end
      rd(IDX_FAULT, FAULT_NONE);
      wr(IDX_ADDR, 16'h00f8);
      rd(IDX_ADDR, 16'h0001);
      wr(IDX_RATE, 16'h0009);
      rd(IDX_RATE, 16'h0005);
      wr(IDX_SCALE, 16'h0001);
      chk("scale", CUR_SCALE_SEL, 16'h0001);
      wr(IDX_TMO, 16'h0001);
      n = 0;
      while (LINK_TIMEOUT_FAULT !== 1'b1 && n < 6000) begin
         @(posedge CLK_SYS);
         n++;
      end
      if (n >= 6000) hang();
      chk("loss time", n > 4850 && n < 5100, 16'h0001);
      rd(IDX_FAULT, FAULT_COMM);
      DRIVE_FAULT <= 16'h0005;
      rd(IDX_FAULT, 16'h0005);
      wr(IDX_TMO, 16'h0000);
      FAULT_CLR <= 1'b1;
      @(posedge CLK_SYS);
      FAULT_CLR <= 1'b0;
      DRIVE_FAULT <= 16'h0000;
      rd(IDX_FAULT, FAULT_NONE);
      dly = 1 + $urandom % 4;
      wr(IDX_RATE, 16'h0008);
      wr(IDX_FMT, 16'h0003);
      wr(IDX_DLY, 16'(dly));
      frame(8'h01);
      chk("own frame", g, 16'h0001);
      chk("bytes", 16'(nval), 16'h0004);
      n = i_host.crc_add(i_host.crc_add(CRC_INIT, 8'h01), FC_READ);
      chk("last byte", 16'(FRM_DATA), 16'(n[15:8]));
      offer(8'h01, 1'b0);
      offer(FC_READ, 1'b1);
      RPL_VALID <= 1'b0;
      n = 0;
      do begin
         @(posedge CLK_SYS);
         n++;
      end while (TX_EN !== 1'b0 && n < 30000);
      if (n >= 30000) hang();
      n = tx_rise - t_good;
      chk("turnaround", n >= dly * 50 - 2 && n <= dly * 50 + 56, 16'h0001);
      chk("reply chars", 16'((tx_hi + 2170) / 4340), 16'h0005);
      n = i_host.crc_add(i_host.crc_add(i_host.crc_add(CRC_INIT, 8'h01), FC_READ), PAD_BYTE);
      chk("reply count", 16'(i_host.ngot), 16'h0005);
      chk("reply head", {i_host.got[1], i_host.got[0]}, {FC_READ, 8'h01});
      chk("reply pad", 16'(i_host.got[2]), 16'(PAD_BYTE));
      chk("reply check", {i_host.got[4], i_host.got[3]}, 16'(n));
      wr(IDX_ADDR, 16'(ADDR_BCAST));
      frame(8'h02);
      chk("other station", b, 16'h0001);
      chk("loss fault", LINK_TIMEOUT_FAULT, 16'h0000);
      chk("broadcast flag", 16'(bc_seen), 16'h0000);
      conclude();
   end
endmodule
